// ### pdmc_pkg.sv
/*
 * Constants and types shared by the power-down mode controller.
 * Assumes a 10 MHz system clock and a 32-bit Avalon-MM register bus.
 */
package pdmc_pkg;
    // ============================================================
    // Register map (indices; byte address is four times the index)
    localparam logic [15:0] PDMC_CTRL_IDX = 16'hfff2;
    localparam logic [15:0] PDMC_STAT_IDX = 16'hfff3;
    localparam int PDMC_ADDR_W = 18;
    localparam logic [17:0] PDMC_CTRL_ADDR = {PDMC_CTRL_IDX, 2'b00};
    localparam logic [17:0] PDMC_STAT_ADDR = {PDMC_STAT_IDX, 2'b00};
    localparam logic [7:0] PDMC_CTRL_RESET = 8'h0b;

    // ============================================================
    // Control register fields
    localparam int PDMC_STANDBY_PIN_N_SEL_BIT = 7;
    localparam int PDMC_SETTLE_MSB = 6;
    localparam int PDMC_SETTLE_LSB = 4;
    localparam int PDMC_RAM_EN_BIT = 0;

    // ============================================================
    // Settling wait: shortest count, doubled per code step
    localparam int PDMC_SETTLE_W = 18;
    localparam logic [17:0] PDMC_SETTLE_BASE = 18'h02000;
    localparam logic [2:0] PDMC_SETTLE_MAX_SHIFT = 3'h4;

    // ============================================================
    // Clocking
    localparam int PDMC_SYS_CLK_HZ = 10_000_000;
    localparam int PDMC_DUTY_FIX_HZ = 5_000_000;
    localparam int PDMC_PRESC_STAGES = 12;
    localparam int PDMC_PERIOD_W = 8;

    // ============================================================
    // Operating modes
    typedef enum logic [2:0] {
        PDMC_RUN,
        PDMC_SLEEP,
        PDMC_SW_STANDBY_PIN_N,
        PDMC_SETTLE,
        PDMC_HW_STANDBY_PIN_N,
        PDMC_RESET
    } pdmc_mode_type;
endpackage : pdmc_pkg

// ### pdmc_top.sv
/*
 * Power-down mode controller: sleep, software and hardware standby,
 * oscillator settling wait, duty correction and prescaler ticks.
 * Assumes all inputs are synchronous to i_sys_clk; the CPU gives a
 * one-cycle halt pulse and level interrupt requests.
 */
// Notes on behaviour
// - Duty-correct oscillator at 5 MHz or more
// - Prescaler ticks divide system clock by 2..4096
// - Halt with standby_select 0 enters sleep
// - Halt with standby_select 1 enters software standby
// - Low standby_pin_n forces hardware standby always
// - Software standby partially reinitialises refresh logic
// - standby_select stays set; only a register write, reset or hardware standby clears it
// - Wake from software standby waits settling time
// - Settle codes give 8192 to 131072 states
// - system_control_reg is 8-bit, read and write
// - Sleep exits on interrupt, reset or standby pin
// - Only NMI, enabled unmasked external interrupts, reset or standby pin end software standby
// - Hardware standby exit goes through reset handling
`timescale 1ns/100ps
module pdmc_top (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // Avalon-MM register slave
    input wire logic [pdmc_pkg::PDMC_ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // CPU and interrupt sources
    input wire logic i_halt_exec,
    input wire logic i_irq_pending,
    input wire logic i_nmi,
    input wire logic [2:0] i_ext_irq,
    input wire logic [2:0] i_ext_irq_en,
    input wire logic i_cpu_masked,
    // Board pins
    input wire logic i_standby_pin_n,
    input wire logic i_power_on_clear_n,
    input wire logic i_osc_raw,
    input wire logic i_osc_fast,
    // Module control
    output logic o_phi,
    output logic [pdmc_pkg::PDMC_PRESC_STAGES-1:0] o_presc_tick,
    output logic o_clock_run,
    output logic o_cpu_halt,
    output logic o_cpu_regs_lost,
    output logic o_dma_reset,
    output logic o_refresh_halt,
    output logic o_refresh_reset,
    output logic o_refresh_partial_init,
    output logic o_periph_halt,
    output logic o_periph_reset,
    output logic o_ports_hiz,
    output logic o_ram_enable,
    output logic o_int_start,
    output logic o_reset_start
);
    import pdmc_pkg::*;

    // Refuse widths that the counters and the tick logic cannot serve
    if (PDMC_PRESC_STAGES < 1 || PDMC_PERIOD_W < 2
        || $bits(PDMC_SETTLE_BASE) != PDMC_SETTLE_W) begin : g_cfg_check
        $error("pdmc_top: counter widths out of range");
    end

    // ============================================================
    // State
    pdmc_mode_type mode_reg, mode_next;
    logic [7:0] ctrl_reg, ctrl_next;
    logic [PDMC_SETTLE_W-1:0] settle_cnt_reg, settle_cnt_next;
    logic waitreq_reg, waitreq_next;
    logic [31:0] rdata_reg, rdata_next;
    logic int_start_reg, int_start_next;
    logic reset_start_reg, reset_start_next;
    logic partial_init_reg, partial_init_next;
    logic [PDMC_PRESC_STAGES-1:0] presc_reg, presc_next;
    logic [PDMC_PRESC_STAGES-1:0] tick_reg, tick_next;
    logic osc_prev_reg, osc_prev_next;
    logic [PDMC_PERIOD_W-1:0] per_cnt_reg, per_cnt_next;
    logic [PDMC_PERIOD_W-1:0] half_reg, half_next;
    logic phi_reg, phi_next;

    // ============================================================
    // Decoded conditions
    logic std_wake;
    logic [2:0] settle_code;
    logic [2:0] settle_shift;
    logic [PDMC_SETTLE_W-1:0] settle_term;
    logic bus_take;
    logic clk_stopped;

    // Enabled and unmasked wake sources for software standby
    assign std_wake = i_nmi | (|(i_ext_irq & i_ext_irq_en) & ~i_cpu_masked);
    assign settle_code = ctrl_reg[PDMC_SETTLE_MSB:PDMC_SETTLE_LSB];
    // Code 10x and the illegal 11x both give the longest wait
    assign settle_shift = settle_code[2] ? PDMC_SETTLE_MAX_SHIFT : settle_code;
    assign settle_term = PDMC_SETTLE_BASE << settle_shift;
    assign bus_take = (i_avs_read | i_avs_write) & ~waitreq_reg;
    assign clk_stopped = (mode_reg == PDMC_SW_STANDBY_PIN_N) || (mode_reg == PDMC_SETTLE)
        || (mode_reg == PDMC_HW_STANDBY_PIN_N);

    // ============================================================
    // Mode sequencer next state
    always_comb begin
        mode_next = mode_reg;
        settle_cnt_next = settle_cnt_reg;
        int_start_next = 1'b0;
        reset_start_next = 1'b0;
        partial_init_next = 1'b0;
        unique case (mode_reg)
            PDMC_RUN: begin
                if (i_halt_exec && ctrl_reg[PDMC_STANDBY_PIN_N_SEL_BIT]) begin
                    mode_next = PDMC_SW_STANDBY_PIN_N;
                    partial_init_next = 1'b1;
                end else if (i_halt_exec) begin
                    mode_next = PDMC_SLEEP;
                end
            end
            PDMC_SLEEP: begin
                if (i_irq_pending || i_nmi) begin
                    mode_next = PDMC_RUN;
                    int_start_next = 1'b1;
                end
            end
            PDMC_SW_STANDBY_PIN_N: begin
                if (std_wake) begin
                    mode_next = PDMC_SETTLE;
                    settle_cnt_next = '0;
                end
            end
            PDMC_SETTLE: begin
                // Count states from oscillator restart to the terminal count
                if (settle_cnt_reg == settle_term - 1'b1) begin
                    mode_next = PDMC_RUN;
                    int_start_next = 1'b1;
                end else begin
                    settle_cnt_next = settle_cnt_reg + 1'b1;
                end
            end
            PDMC_HW_STANDBY_PIN_N: begin
                if (i_standby_pin_n) begin
                    mode_next = PDMC_RESET;
                end
            end
            PDMC_RESET: begin
                if (i_power_on_clear_n) begin
                    mode_next = PDMC_RUN;
                    reset_start_next = 1'b1;
                end
            end
            default: begin
                mode_next = PDMC_RESET;
            end
        endcase
        // Standby pin overrides every state; clear overrides all but hardware standby
        if (!i_standby_pin_n) begin
            mode_next = PDMC_HW_STANDBY_PIN_N;
            int_start_next = 1'b0;
            partial_init_next = 1'b0;
        end else if (!i_power_on_clear_n && mode_reg != PDMC_HW_STANDBY_PIN_N) begin
            mode_next = PDMC_RESET;
            int_start_next = 1'b0;
            partial_init_next = 1'b0;
        end
    end

    // Mode sequencer registers
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mode_reg <= PDMC_RESET;
            settle_cnt_reg <= '0;
            int_start_reg <= 1'b0;
            reset_start_reg <= 1'b0;
            partial_init_reg <= 1'b0;
        end else begin
            mode_reg <= mode_next;
            settle_cnt_reg <= settle_cnt_next;
            int_start_reg <= int_start_next;
            reset_start_reg <= reset_start_next;
            partial_init_reg <= partial_init_next;
        end
    end

    // ============================================================
    // Register slave next state
    always_comb begin
        ctrl_next = ctrl_reg;
        rdata_next = rdata_reg;
        waitreq_next = 1'b1;
        if ((i_avs_read || i_avs_write) && waitreq_reg) begin
            // Answer one cycle after the request is seen
            waitreq_next = 1'b0;
            if (i_avs_address == PDMC_CTRL_ADDR) begin
                rdata_next = {24'h000000, ctrl_reg};
            end else if (i_avs_address == PDMC_STAT_ADDR) begin
                rdata_next = {28'h0000000, (mode_reg == PDMC_SETTLE), mode_reg};
            end else begin
                rdata_next = 32'h00000000;
            end
        end
        if (bus_take && i_avs_write && i_avs_address == PDMC_CTRL_ADDR) begin
            ctrl_next = i_avs_writedata[7:0];
        end
        // Reset and hardware standby reinitialise the register; software standby keeps it
        if (mode_reg == PDMC_RESET || mode_reg == PDMC_HW_STANDBY_PIN_N) begin
            ctrl_next = PDMC_CTRL_RESET;
        end
    end

    // Register slave registers
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_reg <= PDMC_CTRL_RESET;
            rdata_reg <= 32'h00000000;
            waitreq_reg <= 1'b1;
        end else begin
            ctrl_reg <= ctrl_next;
            rdata_reg <= rdata_next;
            waitreq_reg <= waitreq_next;
        end
    end

    // ============================================================
    // Duty correction and prescaler next state
    always_comb begin
        osc_prev_next = i_osc_raw;
        per_cnt_next = per_cnt_reg;
        half_next = half_reg;
        phi_next = i_osc_raw;
        if (i_osc_raw && !osc_prev_reg) begin
            // Measure period between rising edges, keep half of it
            half_next = {1'b0, per_cnt_reg[PDMC_PERIOD_W-1:1]};
            per_cnt_next = '0;
        end else if (per_cnt_reg != '1) begin
            per_cnt_next = per_cnt_reg + 1'b1;
        end
        if (i_osc_fast) begin
            phi_next = (per_cnt_next <= half_reg);
        end
        presc_next = clk_stopped ? '0 : presc_reg + 1'b1;
    end

    // Prescaler tick per division stage
    genvar k;
    generate
        for (k = 0; k < PDMC_PRESC_STAGES; k++) begin : g_tick
            assign tick_next[k] = ~clk_stopped & (&presc_reg[k:0]);
        end
    endgenerate

    // Duty correction and prescaler registers
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            osc_prev_reg <= 1'b0;
            per_cnt_reg <= '0;
            half_reg <= '0;
            phi_reg <= 1'b0;
            presc_reg <= '0;
            tick_reg <= '0;
        end else begin
            osc_prev_reg <= osc_prev_next;
            per_cnt_reg <= per_cnt_next;
            half_reg <= half_next;
            phi_reg <= phi_next;
            presc_reg <= presc_next;
            tick_reg <= tick_next;
        end
    end

    // ============================================================
    // Module control outputs, decoded into flops
    logic clock_run_reg, cpu_halt_reg, regs_lost_reg, dma_rst_reg;
    logic rf_halt_reg, rf_rst_reg, pf_halt_reg, pf_rst_reg, hiz_reg;
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            clock_run_reg <= 1'b0;
            cpu_halt_reg <= 1'b1;
            regs_lost_reg <= 1'b1;
            dma_rst_reg <= 1'b1;
            rf_halt_reg <= 1'b1;
            rf_rst_reg <= 1'b1;
            pf_halt_reg <= 1'b1;
            pf_rst_reg <= 1'b1;
            hiz_reg <= 1'b1;
        end else begin
            clock_run_reg <= (mode_next == PDMC_RUN) || (mode_next == PDMC_SLEEP)
                || (mode_next == PDMC_RESET);
            cpu_halt_reg <= (mode_next != PDMC_RUN);
            regs_lost_reg <= (mode_next == PDMC_HW_STANDBY_PIN_N);
            dma_rst_reg <= (mode_next == PDMC_SW_STANDBY_PIN_N) || (mode_next == PDMC_SETTLE)
                || (mode_next == PDMC_HW_STANDBY_PIN_N) || (mode_next == PDMC_RESET);
            rf_halt_reg <= (mode_next != PDMC_RUN) && (mode_next != PDMC_SLEEP);
            rf_rst_reg <= (mode_next == PDMC_HW_STANDBY_PIN_N) || (mode_next == PDMC_RESET);
            pf_halt_reg <= (mode_next != PDMC_RUN) && (mode_next != PDMC_SLEEP);
            pf_rst_reg <= (mode_next == PDMC_SW_STANDBY_PIN_N) || (mode_next == PDMC_SETTLE)
                || (mode_next == PDMC_HW_STANDBY_PIN_N) || (mode_next == PDMC_RESET);
            hiz_reg <= (mode_next == PDMC_HW_STANDBY_PIN_N);
        end
    end

    // Output wiring
    assign o_avs_readdata = rdata_reg;
    assign o_avs_waitrequest = waitreq_reg;
    assign o_phi = phi_reg;
    assign o_presc_tick = tick_reg;
    assign o_clock_run = clock_run_reg;
    assign o_cpu_halt = cpu_halt_reg;
    assign o_cpu_regs_lost = regs_lost_reg;
    assign o_dma_reset = dma_rst_reg;
    assign o_refresh_halt = rf_halt_reg;
    assign o_refresh_reset = rf_rst_reg;
    assign o_refresh_partial_init = partial_init_reg;
    assign o_periph_halt = pf_halt_reg;
    assign o_periph_reset = pf_rst_reg;
    assign o_ports_hiz = hiz_reg;
    assign o_ram_enable = ctrl_reg[PDMC_RAM_EN_BIT];
    assign o_int_start = int_start_reg;
    assign o_reset_start = reset_start_reg;
endmodule : pdmc_top

// ### pdmc_board_model.sv
/*
 * Board model: oscillator sample, standby pin and power-on clear pin.
 * Assumes its tasks are called just after a rising clock edge.
 */
`timescale 1ns/100ps
module pdmc_board_model (
    // Clock
    input wire logic i_sys_clk,
    // Board pins
    output logic o_osc,
    output logic o_standby_pin_n,
    output logic o_power_on_clear_n
);
    localparam int POR_HOLD = 5000; // 500 us of 100 ns cycles
    // ====
    // Pins idle at power-up with clear asserted
    initial begin
        o_osc = 1'b0;
        o_standby_pin_n = 1'b1;
        o_power_on_clear_n = 1'b0;
    end
    // Free-running oscillator sample
    always @(posedge i_sys_clk) begin
        o_osc <= ~o_osc;
    end
    // Keep clear low while the clock settles
    task power_up;
        repeat (POR_HOLD) @(posedge i_sys_clk);
        o_power_on_clear_n <= 1'b1;
    endtask : power_up
    // Clear goes low first, then standby
    task enter_hw;
        o_power_on_clear_n <= 1'b0;
        @(posedge i_sys_clk);
        o_standby_pin_n <= 1'b0;
    endtask : enter_hw
    // Standby released under clear, then clear released after settling
    task leave_hw;
        o_standby_pin_n <= 1'b1;
        power_up();
    endtask : leave_hw
endmodule : pdmc_board_model

// ### pdmc_assertions.sv
/*
 * Port checker for the power-down mode controller.
 * Assumes a single clock domain; bound to every pdmc_top instance.
 */
`timescale 1ns/100ps
module pdmc_assertions (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // Bus and control inputs
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic o_avs_waitrequest,
    input wire logic i_halt_exec,
    input wire logic i_standby_pin_n,
    input wire logic i_power_on_clear_n,
    // Module control outputs
    input wire logic [pdmc_pkg::PDMC_PRESC_STAGES-1:0] o_presc_tick,
    input wire logic o_clock_run,
    input wire logic o_cpu_halt,
    input wire logic o_cpu_regs_lost,
    input wire logic o_dma_reset,
    input wire logic o_periph_reset,
    input wire logic o_refresh_partial_init,
    input wire logic o_ports_hiz,
    input wire logic o_int_start,
    input wire logic o_reset_start
);
    import pdmc_pkg::*;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    localparam int SETTLE_MIN = 8192;
    logic [17:0] gap_reg, gap_next;
    logic armed_reg, armed_next;
    // ====
    // Cycles since entry to software standby, saturating
    always_comb begin
        gap_next = (gap_reg == '1) ? gap_reg : gap_reg + 18'h1;
        armed_next = armed_reg;
        if (o_refresh_partial_init) begin
            gap_next = '0;
            armed_next = 1'b1;
        end else if (o_int_start || o_reset_start) begin
            armed_next = 1'b0;
        end
    end
    // Helper registers
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            gap_reg <= '0;
            armed_reg <= 1'b0;
        end else begin
            gap_reg <= gap_next;
            armed_reg <= armed_next;
        end
    end
    // ====
    // Bus steps: request waiting, then one low answer cycle
    sequence s_req;
        (i_avs_read || i_avs_write) && o_avs_waitrequest;
    endsequence
    sequence s_answer;
        !o_avs_waitrequest ##1 o_avs_waitrequest;
    endsequence
    a_bus_answer: assert property (s_req |=> s_answer)
        else $error("bus answer not one cycle after request");
    a_pin_standby: assert property (!i_standby_pin_n |=> o_ports_hiz && o_cpu_regs_lost
        && !o_clock_run && o_periph_reset && o_dma_reset)
        else $error("standby pin did not force hardware standby");
    a_halt_stops: assert property ((i_halt_exec && !o_cpu_halt && i_standby_pin_n
        && i_power_on_clear_n) |=> o_cpu_halt)
        else $error("halt did not stop the cpu");
    a_sw_entry: assert property (o_refresh_partial_init |-> !o_clock_run && o_dma_reset
        && o_periph_reset && !o_cpu_regs_lost && !o_ports_hiz ##1 !o_refresh_partial_init)
        else $error("software standby entry outputs wrong");
    a_tick_pulse: assert property ((o_presc_tick[0] && o_clock_run) |=> !o_presc_tick[0])
        else $error("divide-by-2 tick not a single cycle");
    a_reset_exit: assert property (o_reset_start |-> o_clock_run && !o_cpu_halt
        && !o_ports_hiz && $past(i_power_on_clear_n))
        else $error("reset handling started while clear low");
    a_settle_min: assert property ((o_int_start && armed_reg) |-> gap_reg >= SETTLE_MIN)
        else $error("standby wake before shortest settling time");
    a_int_runs: assert property (o_int_start |-> o_clock_run && !o_cpu_halt)
        else $error("interrupt start without running cpu");
endmodule : pdmc_assertions

bind pdmc_top pdmc_assertions pdmc_assertions_i (.*);

// ### tb_power_down_mode_control.sv
/*
 * Testbench for the power-down mode controller.
 * Assumes pdmc_pkg, pdmc_top, the board model and the checker are compiled first.
 */
`timescale 1ns/100ps
module tb_power_down_mode_control;
    import pdmc_pkg::*;
    typedef struct {logic [17:0] a; logic w; logic [31:0] d; logic [31:0] e;} pdmc_row_type;
    logic i_sys_clk, i_rst_n, i_avs_read, i_avs_write, o_avs_waitrequest, i_halt_exec;
    logic i_irq_pending, i_nmi, i_cpu_masked, i_standby_pin_n, i_power_on_clear_n;
    logic i_osc_raw, i_osc_fast, o_phi, o_clock_run, o_cpu_halt, o_cpu_regs_lost;
    logic o_dma_reset, o_refresh_halt, o_refresh_reset, o_refresh_partial_init;
    logic o_periph_halt, o_periph_reset, o_ports_hiz, o_ram_enable, o_int_start, o_reset_start;
    logic [PDMC_ADDR_W-1:0] i_avs_address;
    logic [31:0] i_avs_writedata, o_avs_readdata, q;
    logic [2:0] i_ext_irq, i_ext_irq_en;
    logic [PDMC_PRESC_STAGES-1:0] o_presc_tick;
    int error_cnt, checks_done, c;
    // Register cases: optional write, then read-back
    pdmc_row_type rows [5] = '{
        '{PDMC_CTRL_ADDR, 1'b1, 32'h3a, 32'h3a},
        '{PDMC_CTRL_ADDR, 1'b1, 32'hff, 32'hff},
        '{18'h00000, 1'b1, 32'h55, 32'h0},
        '{PDMC_STAT_ADDR, 1'b0, 32'h0, 32'h0},
        '{PDMC_CTRL_ADDR, 1'b1, 32'h0b, 32'h0b}};
    // ====
    // Design, board and clock
    pdmc_top pdmc_top_i (.*);
    pdmc_board_model pdmc_board_model_i (.i_sys_clk(i_sys_clk), .o_osc(i_osc_raw),
        .o_standby_pin_n(i_standby_pin_n), .o_power_on_clear_n(i_power_on_clear_n));
    initial begin
        i_sys_clk = 1'b0;
        forever #50 i_sys_clk = ~i_sys_clk;
    end
    // ====
    // Compare and count
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // One bus access, held until waitrequest is sampled low
    task automatic bus(input bit w, input logic [17:0] a, input logic [31:0] d);
        i_avs_address <= a;
        i_avs_writedata <= d;
        i_avs_write <= w;
        i_avs_read <= ~w;
        @(posedge i_sys_clk);
        while (o_avs_waitrequest !== 1'b0) @(posedge i_sys_clk);
        // Answer edge: take read data here, then release
        q = o_avs_readdata;
        i_avs_write <= 1'b0;
        i_avs_read <= 1'b0;
        @(posedge i_sys_clk);
    endtask : bus
    // Count edges until int or reset start pulses
    task automatic wait_pulse(input bit rs, input int lim);
        c = 0;
        @(negedge i_sys_clk);
        while ((rs ? o_reset_start : o_int_start) !== 1'b1 && c < lim) begin
            c++;
            @(negedge i_sys_clk);
        end
        @(posedge i_sys_clk);
    endtask : wait_pulse
    // Halt instruction pulse
    task halt_pulse;
        i_halt_exec <= 1'b1;
        @(posedge i_sys_clk);
        i_halt_exec <= 1'b0;
        @(posedge i_sys_clk);
    endtask : halt_pulse
    // Verdict and end of run
    task final_report;
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : final_report
    // Watchdog, about twice the expected run
    initial begin
        repeat (90000) @(posedge i_sys_clk);
        error_cnt++;
        $display("BAD watchdog expected done seen hang");
        final_report();
    end
    // ====
    // Main sequence
    initial begin
        {i_rst_n, i_avs_read, i_avs_write, i_halt_exec, i_irq_pending, i_nmi} = '0;
        {i_cpu_masked, i_osc_fast, i_avs_address, i_avs_writedata, i_ext_irq, i_ext_irq_en} = '0;
        repeat (6) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        @(posedge i_sys_clk);
        bus(0, PDMC_CTRL_ADDR, 0);
        chk("ctrl reset", PDMC_CTRL_RESET, q);
        chk("clock in reset", 1, o_clock_run);
        pdmc_board_model_i.power_up();
        wait_pulse(1, 10);
        chk("reset start", 1, c < 10);
        foreach (rows[i]) begin
            if (rows[i].w) bus(1, rows[i].a, rows[i].d);
            bus(0, rows[i].a, 0);
            chk("reg row", rows[i].e, q);
        end
        halt_pulse();
        chk("sleep outs", 4'b1010, {o_clock_run, o_dma_reset, o_cpu_halt, o_periph_halt});
        chk("sleep refresh", 0, o_refresh_halt);
        i_irq_pending <= 1'b1;
        wait_pulse(0, 10);
        chk("sleep wake", 1, c < 10);
        i_irq_pending <= 1'b0;
        for (int k = 0; k < 2; k++) begin
            // External clock on the board, so short settle codes are allowed
            bus(1, PDMC_CTRL_ADDR, {24'h0, 1'b1, k[2:0], 4'hb});
            halt_pulse();
            chk("sw outs", 4'b0110, {o_clock_run, o_dma_reset, o_periph_reset, o_cpu_regs_lost});
            chk("sw refresh", 1, o_refresh_halt);
            i_ext_irq <= 3'h4;
            i_ext_irq_en <= 3'h3;
            repeat (20) @(posedge i_sys_clk);
            i_ext_irq_en <= 3'h4;
            i_cpu_masked <= 1'b1;
            repeat (20) @(posedge i_sys_clk);
            bus(0, PDMC_STAT_ADDR, 0);
            chk("no wake", 32'h2, q);
            if (k == 0) i_cpu_masked <= 1'b0;
            else i_nmi <= 1'b1;
            wait_pulse(0, 20000);
            chk("settle", 1, c >= (8192 << k) && c <= (8192 << k) + 2);
            {i_ext_irq, i_ext_irq_en, i_cpu_masked, i_nmi} <= '0;
            bus(0, PDMC_CTRL_ADDR, 0);
            chk("select kept", {24'h0, 1'b1, k[2:0], 4'hb}, q);
        end
        bus(1, PDMC_CTRL_ADDR, 32'h0a);
        chk("ram off", 0, o_ram_enable);
        pdmc_board_model_i.enter_hw();
        repeat (3) @(posedge i_sys_clk);
        chk("hw outs", 4'b1110, {o_ports_hiz, o_cpu_regs_lost, o_refresh_reset, o_clock_run});
        bus(1, PDMC_CTRL_ADDR, 32'h80);
        bus(0, PDMC_CTRL_ADDR, 0);
        chk("hw ctrl", PDMC_CTRL_RESET, q);
        pdmc_board_model_i.leave_hw();
        wait_pulse(1, 10);
        chk("hw exit", 1, c < 10);
        // Fast oscillator: corrected clock high for half of each period
        i_osc_fast <= 1'b1;
        repeat (8) @(posedge i_sys_clk);
        c = 0;
        repeat (8) begin
            @(negedge i_sys_clk);
            c += (o_phi === 1'b1);
        end
        chk("duty", 4, c);
        for (int k = 0; k < 12; k += 11) begin
            @(negedge i_sys_clk);
            while (o_presc_tick[k] !== 1'b1) @(negedge i_sys_clk);
            c = 0;
            do begin
                c++;
                @(negedge i_sys_clk);
            end while (o_presc_tick[k] !== 1'b1 && c < 5000);
            chk("tick period", 2 << k, c);
        end
        final_report();
    end
endmodule : tb_power_down_mode_control
